/* logic/gpcfg_pkg.sv */
// constants, sub-register index codes and decode helpers for the port configuration block
// assumes one system clock and an asynchronous active-high system reset
package gpcfg_pkg;
    localparam int NPORT = 4;
    localparam int PW = 8;
    localparam int PINS = NPORT * PW;
    localparam int NALT = 4;
    // index register of port n at base plus four n, control register one above
    localparam logic [11:0] PORT_BLOCK_BASE = 12'hFD0;
    localparam logic [1:0] ADDR_LANE = 2'h0;
    localparam logic [1:0] CTRL_LANE = 2'h1;
    localparam logic [7:0] IDX_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] IDX_WAKE_SRC = 8'h05;
    localparam logic [7:0] IDX_AFS_TWO = 8'h08;
    localparam logic [7:0] IDX_RST = 8'h00;
    localparam logic [7:0] HDE_RST = 8'h00;
    localparam logic [7:0] WAKE_RST = 8'h00;
    localparam logic [7:0] AFS2_RST = 8'h00;
    localparam logic [7:0] AFS2_RST_SMALL_A = 8'h04;
    localparam logic [7:0] RD_IDLE = 8'h00;

    typedef enum logic [1:0] {
        SUB_NONE = 2'b00,
        SUB_HDE = 2'b01,
        SUB_WAKE = 2'b10,
        SUB_AFS2 = 2'b11
    } gpcfg_sub_t;

    function automatic gpcfg_sub_t gpcfg_sub_of(input logic [7:0] idx);
        gpcfg_sub_t s;
        s = SUB_NONE;
        if (idx == IDX_HIGH_DRIVE) s = SUB_HDE;
        if (idx == IDX_WAKE_SRC) s = SUB_WAKE;
        if (idx == IDX_AFS_TWO) s = SUB_AFS2;
        return s;
    endfunction
endpackage

/* logic/gpcfg_port.sv */
// four 8-pin ports: indexed sub-register access, pin driver control,
// port A fixed alternate-function map and stop-mode wake detection
// assumes data, direction, open-drain, set 1 and enable bits come from registers outside
`timescale 1ns/1ps
module gpcfg_port import gpcfg_pkg::*; #(
    parameter bit SMALL_PKG = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register access
    input wire logic [11:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // port settings held outside this block
    input wire logic [PINS-1:0] portData,
    input wire logic [PINS-1:0] portDirOut,
    input wire logic [PINS-1:0] afEnable,
    input wire logic [PINS-1:0] afSelOne,
    input wire logic [PINS-1:0] openDrain,
    // alternate functions of ports B to D, four per pin
    input wire logic [(PINS-PW)*NALT-1:0] altOutData,
    input wire logic [(PINS-PW)*NALT-1:0] altOutEn,
    // port A peripheral side
    input wire logic timerZeroPinIsInput,
    input wire logic timerZeroOutput,
    input wire logic timerZeroOutputComp,
    input wire logic timerOnePinIsInput,
    input wire logic timerOneOutput,
    input wire logic timerOneOutputComp,
    input wire logic serialDriverEnable,
    input wire logic serialTransmit,
    output logic timerZeroInput,
    output logic timerOneInput,
    output logic serialClearToSend,
    output logic serialReceive,
    // power
    input wire logic stopMode,
    output logic stopRecoveryReq,
    // pins
    input wire logic [PINS-1:0] padIn,
    output logic [PINS-1:0] padOut,
    output logic [PINS-1:0] padOeN,
    output logic [PINS-1:0] padHighDrive,
    output logic [PINS-1:0] padSourceOff
);
    logic [PINS-1:0] pinSync, pinPrev_r, hdeBits, wakeBits, afsTwoBits;
    logic [PINS-1:0] padOut_r, padOeN_r, padHighDrive_r, padSourceOff_r;
    logic [NPORT-1:0][7:0] idx_r;
    logic regRdValid_r, stopRecoveryReq_r;
    logic timerZeroInput_r, timerOneInput_r, serialClearToSend_r, serialReceive_r;
    gpcfg_sub_t curSub;

    // register decode
    wire blockHit = (regAddr[11:4] == PORT_BLOCK_BASE[11:4]);
    wire addrHit = blockHit && (regAddr[1:0] == ADDR_LANE);
    wire ctrlHit = blockHit && (regAddr[1:0] == CTRL_LANE);
    wire [1:0] portSel = regAddr[3:2];
    wire [7:0] curIdx = idx_r[portSel];
    assign curSub = gpcfg_sub_of(curIdx);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_r <= {NPORT{IDX_RST}};
        end else if (regWrEn && addrHit) begin
            idx_r[portSel] <= regWrData;
        end
    end

    // unknown indices: writes dropped, reads give zero
    gpcfg_regbank #(.SMALL_PKG(SMALL_PKG)) u_bank (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(regWrEn && ctrlHit),
        .wrPort(portSel),
        .wrSub(curSub),
        .wrData(regWrData),
        .rdEn(regRdEn),
        .rdPort(portSel),
        .rdSub(ctrlHit ? curSub : SUB_NONE),
        .rdIdxSel(addrHit),
        .rdIdx(curIdx),
        .rdData(regRdData),
        .hdeBits(hdeBits),
        .wakeBits(wakeBits),
        .afsTwoBits(afsTwoBits)
    );

    gpcfg_sync #(.W(PINS)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(padIn),
        .syncOut(pinSync)
    );

    // port A fixed map, bit 7 down to 0
    wire [PW-1:0] paAltOut = {timerOneOutput, timerOneOutputComp, serialTransmit, 1'b1,
                              1'b1, serialDriverEnable, timerZeroOutput, timerZeroOutputComp};
    wire [PW-1:0] paAltDrv = {1'b1, ~timerOnePinIsInput, 1'b1, 1'b0,
                              1'b0, 1'b1, 1'b1, ~timerZeroPinIsInput};

    wire [PINS-1:0] outNxt;
    wire [PINS-1:0] drvNxt;
    wire [PINS-1:0] oeNNxt;

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        wire altOut;
        wire altDrv;
        if (i < PW) begin : g_pa
            // no set bits on port A
            assign altOut = paAltOut[i];
            assign altDrv = paAltDrv[i];
        end else begin : g_px
            // set 2 and set 1 pick function
            wire [1:0] sel = {afsTwoBits[i], afSelOne[i]};
            wire [NALT-1:0] dataGrp = altOutData[(i-PW)*NALT +: NALT];
            wire [NALT-1:0] enGrp = altOutEn[(i-PW)*NALT +: NALT];
            assign altOut = dataGrp[sel];
            assign altDrv = enGrp[sel];
        end
        assign outNxt[i] = afEnable[i] ? altOut : portData[i];
        assign drvNxt[i] = afEnable[i] ? altDrv : portDirOut[i];
        // open drain drops the high side
        assign oeNNxt[i] = ~(drvNxt[i] & ~(openDrain[i] & outNxt[i]));
    end

    wire [PINS-1:0] pinChange = pinSync ^ pinPrev_r;
    wire wakeHit = stopMode && (|(pinChange & wakeBits));

    // inputs to timers idle low, serial inputs idle high when not routed
    wire timer_zero_input = (afEnable[0] && timerZeroPinIsInput) ? pinSync[0] : 1'b0;
    wire timer_one_input = (afEnable[6] && timerOnePinIsInput) ? pinSync[6] : 1'b0;
    wire ctsIn = afEnable[3] ? pinSync[3] : 1'b1;
    wire rxIn = afEnable[4] ? pinSync[4] : 1'b1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            padOut_r <= '0;
            padOeN_r <= '1;
            padHighDrive_r <= '0;
            padSourceOff_r <= '0;
            pinPrev_r <= '0;
            stopRecoveryReq_r <= 1'b0;
            regRdValid_r <= 1'b0;
            timerZeroInput_r <= 1'b0;
            timerOneInput_r <= 1'b0;
            serialClearToSend_r <= 1'b1;
            serialReceive_r <= 1'b1;
        end else begin
            padOut_r <= outNxt;
            padOeN_r <= oeNNxt;
            padHighDrive_r <= hdeBits;
            padSourceOff_r <= openDrain;
            pinPrev_r <= pinSync;
            stopRecoveryReq_r <= wakeHit;
            regRdValid_r <= regRdEn && (addrHit || ctrlHit);
            timerZeroInput_r <= timer_zero_input;
            timerOneInput_r <= timer_one_input;
            serialClearToSend_r <= ctsIn;
            serialReceive_r <= rxIn;
        end
    end

    assign padOut = padOut_r;
    assign padOeN = padOeN_r;
    assign padHighDrive = padHighDrive_r;
    assign padSourceOff = padSourceOff_r;
    assign stopRecoveryReq = stopRecoveryReq_r;
    assign regRdValid = regRdValid_r;
    assign timerZeroInput = timerZeroInput_r;
    assign timerOneInput = timerOneInput_r;
    assign serialClearToSend = serialClearToSend_r;
    assign serialReceive = serialReceive_r;

    // checks; port A addresses and port B pins 8 and 9 used as samples
    localparam logic [11:0] A_ADDR = PORT_BLOCK_BASE;
    localparam logic [11:0] A_CTRL = PORT_BLOCK_BASE + 12'h001;
    logic firstCycle_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) firstCycle_r <= 1'b1;
        else firstCycle_r <= 1'b0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seqPickA(logic [7:0] idx);
        regWrEn && regAddr == A_ADDR && regWrData == idx;
    endsequence
    sequence seqCtrlWrA;
        regWrEn && regAddr == A_CTRL;
    endsequence

    AST_HDE_INDEXED: assert property (seqPickA(IDX_HIGH_DRIVE) ##1 seqCtrlWrA |=> hdeBits[7:0] == $past(regWrData))
        else $error("high drive write via index 04 lost");
    AST_HDE_TO_PAD: assert property (seqPickA(IDX_HIGH_DRIVE) ##1 seqCtrlWrA |=> ##1 padHighDrive[7:0] == $past(regWrData, 2))
        else $error("high drive bits not on pads");
    AST_HDE_ALT: assert property (afEnable[1] && $stable(hdeBits) |=> padHighDrive[1] == $past(hdeBits[1], 2))
        else $error("high drive lost under alternate function");
    AST_WAKE_INDEXED: assert property (seqPickA(IDX_WAKE_SRC) ##1 seqCtrlWrA |=> wakeBits[7:0] == $past(regWrData))
        else $error("wake source write via index 05 lost");
    AST_WAKE_FIRES: assert property (stopMode && (|(pinChange & wakeBits)) |=> stopRecoveryReq)
        else $error("enabled pin change did not wake");
    AST_WAKE_MASKED: assert property (stopRecoveryReq |-> $past(stopMode) && $past(|(pinChange & wakeBits)))
        else $error("wake without enabled pin change in stop");
    AST_AFS2_INDEXED: assert property (seqPickA(IDX_AFS_TWO) ##1 seqCtrlWrA |=> afsTwoBits[7:0] == $past(regWrData))
        else $error("set 2 write via index 08 lost");
    AST_AFS2_RESET: assert property (firstCycle_r |-> afsTwoBits[15:8] == AFS2_RST && afsTwoBits[7:0] == (SMALL_PKG ? AFS2_RST_SMALL_A : AFS2_RST))
        else $error("set 2 reset value wrong");
    AST_GPIO_WHEN_OFF: assert property (!afEnable[8] && portDirOut[8] && !openDrain[8] |=> padOut[8] == $past(portData[8]) && !padOeN[8])
        else $error("port data not on pin with function off");
    AST_PA1_TIMER: assert property (afEnable[1] && !openDrain[1] |=> padOut[1] == $past(timerZeroOutput) && !padOeN[1])
        else $error("timer 0 output not on port A bit 1");
    AST_PA0_INPUT: assert property (afEnable[0] && timerZeroPinIsInput |=> padOeN[0])
        else $error("timer 0 input pin still driven");
    AST_OPEN_DRAIN: assert property (openDrain[9] && !afEnable[9] && portData[9] |=> padOeN[9] && padSourceOff[9])
        else $error("open drain pin sourced high");
endmodule

/* logic/gpcfg_regbank.sv */
// per-port sub-register storage with a registered read port
// assumes writes and reads are already decoded to port and sub-register
`timescale 1ns/1ps
module gpcfg_regbank import gpcfg_pkg::*; #(
    parameter bit SMALL_PKG = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // write side
    input wire logic wrEn,
    input wire logic [1:0] wrPort,
    input wire gpcfg_sub_t wrSub,
    input wire logic [7:0] wrData,
    // read side
    input wire logic rdEn,
    input wire logic [1:0] rdPort,
    input wire gpcfg_sub_t rdSub,
    input wire logic rdIdxSel,
    input wire logic [7:0] rdIdx,
    output logic [7:0] rdData,
    // parallel contents
    output logic [PINS-1:0] hdeBits,
    output logic [PINS-1:0] wakeBits,
    output logic [PINS-1:0] afsTwoBits
);
    logic [NPORT-1:0][7:0] hde_r, wake_r, afs2_r;
    logic [7:0] rdData_r;

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        localparam logic [7:0] AFS2_INIT = (SMALL_PKG && p == 0) ? AFS2_RST_SMALL_A : AFS2_RST;
        wire hit = wrEn && (wrPort == 2'(p));
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                hde_r[p] <= HDE_RST;
                wake_r[p] <= WAKE_RST;
                afs2_r[p] <= AFS2_INIT;
            end else if (hit) begin
                if (wrSub == SUB_HDE) hde_r[p] <= wrData;
                if (wrSub == SUB_WAKE) wake_r[p] <= wrData;
                if (wrSub == SUB_AFS2) afs2_r[p] <= wrData;
            end
        end
    end

    wire [7:0] subVal = (rdSub == SUB_HDE) ? hde_r[rdPort] :
                        (rdSub == SUB_WAKE) ? wake_r[rdPort] :
                        (rdSub == SUB_AFS2) ? afs2_r[rdPort] : RD_IDLE;
    wire [7:0] rdData_nxt = rdIdxSel ? rdIdx : subVal;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) rdData_r <= RD_IDLE;
        else if (rdEn) rdData_r <= rdData_nxt;
    end

    assign rdData = rdData_r;
    assign hdeBits = hde_r;
    assign wakeBits = wake_r;
    assign afsTwoBits = afs2_r;
endmodule

/* logic/gpcfg_sync.sv */
// three-stage pin synchroniser with a two-stage agreement filter
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module gpcfg_sync import gpcfg_pkg::*; #(
    parameter int W = PINS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins in, filtered level out
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    // first stage feeds only the second
    wire [W-1:0] agree = ~(s2_r ^ s3_r);
    wire [W-1:0] q_nxt = (q_r & ~agree) | (s3_r & agree);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= asyncIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end
    assign syncOut = q_r;
endmodule

/* verification/gpcfg_pin_model.sv */
// board side of every port pin: external drivers and pull-ups
// assumes the port block's output enables are low while it drives
`timescale 1ns/1ps
module gpcfg_pin_model import gpcfg_pkg::*; (
    // from the port block
    padOut,
    padOeN,
    padSourceOff,
    // external side
    extEn,
    extLevel,
    pinLevel
);
    input wire logic [PINS-1:0] padOut;
    input wire logic [PINS-1:0] padOeN;
    input wire logic [PINS-1:0] padSourceOff;
    input wire logic [PINS-1:0] extEn;
    input wire logic [PINS-1:0] extLevel;
    output logic [PINS-1:0] pinLevel;

    // source off: high comes from the external driver or the pull-up
    // released pins follow the external driver when enabled, else the pull-up, never a held value
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (!padOeN[i] && !(padSourceOff[i] && padOut[i])) pinLevel[i] = padOut[i];
            else if (extEn[i]) pinLevel[i] = extLevel[i];
            else pinLevel[i] = 1'h1;
        end
    end
endmodule

/* verification/tb_port_pin_drive_wake_altfunc.sv */
// self-checking bench for the port configuration block
// assumes the pin model on every pad and one clock domain
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin numErrors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_port_pin_drive_wake_altfunc import gpcfg_pkg::*;;
    localparam logic [7:0] IDXS [3] = '{IDX_HIGH_DRIVE, IDX_WAKE_SRC, IDX_AFS_TWO};
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [11:0] regAddr = 12'h000;
    logic regWrEn = 1'h0;
    logic regRdEn = 1'h0;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic regRdValid;
    logic [PINS-1:0] portData = '0, portDirOut = '0, afEnable = '0, afSelOne = '0, openDrain = '0;
    logic [(PINS-PW)*NALT-1:0] altOutData = '0, altOutEn = '0;
    logic timer_zero_input = 1'h0, timer_zero_output = 1'h0, t0Comp = 1'h0, timer_one_input = 1'h0, timer_one_output = 1'h0, t1Comp = 1'h0;
    logic de = 1'h0, tx = 1'h0, stopMode = 1'h0;
    logic t0Rx, t1Rx, cts, rx, stopReq;
    logic [PINS-1:0] pinLevel, padOut, padOeN, padHighDrive, padSourceOff;
    logic [PINS-1:0] extLevel = '1;
    logic [PINS-1:0] extEn = '1;
    logic [7:0] hde [4];
    logic [7:0] afs2 [4];
    logic [7:0] d;
    logic v;
    int numErrors = 0, nTests = 0, cycles = 0, n;

    always #4 clk = ~clk;

    gpcfg_port gpcfg_port_inst (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .portData(portData), .portDirOut(portDirOut), .afEnable(afEnable), .afSelOne(afSelOne),
        .openDrain(openDrain), .altOutData(altOutData), .altOutEn(altOutEn),
        .timerZeroPinIsInput(timer_zero_input), .timerZeroOutput(timer_zero_output), .timerZeroOutputComp(t0Comp),
        .timerOnePinIsInput(timer_one_input), .timerOneOutput(timer_one_output), .timerOneOutputComp(t1Comp),
        .serialDriverEnable(de), .serialTransmit(tx), .timerZeroInput(t0Rx), .timerOneInput(t1Rx),
        .serialClearToSend(cts), .serialReceive(rx), .stopMode(stopMode), .stopRecoveryReq(stopReq),
        .padIn(pinLevel), .padOut(padOut), .padOeN(padOeN), .padHighDrive(padHighDrive),
        .padSourceOff(padSourceOff));

    gpcfg_pin_model gpcfg_pin_model_inst (.padOut(padOut), .padOeN(padOeN), .padSourceOff(padSourceOff),
        .extEn(extEn), .extLevel(extLevel), .pinLevel(pinLevel));

    function automatic logic [11:0] adr(input int p, input logic [1:0] lane);
        return PORT_BLOCK_BASE + 12'(4 * p) + {10'h000, lane};
    endfunction

    // ports B to D: {set 2, set 1} picks the function
    function automatic logic [1:0] expPin(input int i);
        int s;
        s = (i - PW) * NALT + int'({afs2[i / PW][i % PW], afSelOne[i]});
        if (afEnable[i]) return {altOutData[s], !altOutEn[s]};
        return {portData[i], !portDirOut[i]};
    endfunction

    task automatic regRead(input logic [11:0] a);
        @(posedge clk) #1;
        regAddr = a;
        regRdEn = 1'h1;
        @(posedge clk) #1;
        regRdEn = 1'h0;
        d = regRdData;
        v = regRdValid;
    endtask

    // index and control access in back-to-back cycles, strobe held between
    task automatic setSub(input int p, input logic [7:0] idx, input logic [7:0] w);
        @(posedge clk) #1;
        regAddr = adr(p, ADDR_LANE);
        regWrData = idx;
        regWrEn = 1'h1;
        @(posedge clk) #1;
        regAddr = adr(p, CTRL_LANE);
        regWrData = w;
        @(posedge clk) #1;
        regWrEn = 1'h0;
    endtask

    task automatic getSub(input int p, input logic [7:0] idx);
        @(posedge clk) #1;
        regAddr = adr(p, ADDR_LANE);
        regWrData = idx;
        regWrEn = 1'h1;
        @(posedge clk) #1;
        regWrEn = 1'h0;
        regAddr = adr(p, CTRL_LANE);
        regRdEn = 1'h1;
        @(posedge clk) #1;
        regRdEn = 1'h0;
        d = regRdData;
        v = regRdValid;
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // wake pulses seen in a window longer than the filter delay
    task automatic watchWake();
        n = 0;
        repeat (12) begin
            @(posedge clk) #1;
            n += int'(stopReq === 1'h1);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // whole run needs about 500 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            numErrors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'h14688D06));
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        for (int p = 0; p < NPORT; p++) begin
            foreach (IDXS[k]) begin
                getSub(p, IDXS[k]);
                `CHK({v, d}, 9'h100)
            end
        end
        `CHK(padHighDrive, 32'h00000000)
        for (int p = 0; p < NPORT; p++) begin
            hde[p] = (p == 0) ? 8'hFF : 8'($urandom);
            afs2[p] = 8'($urandom);
            setSub(p, IDX_HIGH_DRIVE, hde[p]);
            setSub(p, IDX_WAKE_SRC, ~hde[p]);
            setSub(p, IDX_AFS_TWO, afs2[p]);
        end
        for (int p = 0; p < NPORT; p++) begin
            getSub(p, IDX_HIGH_DRIVE);
            `CHK(d, hde[p])
            getSub(p, IDX_WAKE_SRC);
            `CHK(d, ~hde[p])
            getSub(p, IDX_AFS_TWO);
            `CHK(d, afs2[p])
        end
        getSub(1, 8'h03);
        `CHK({v, d}, 9'h100)
        regRead(12'hFD2);
        `CHK({v, d}, 9'h000)
        settle(2);
        `CHK(padHighDrive, {hde[3], hde[2], hde[1], hde[0]})
        for (int it = 0; it < 24; it++) begin
            afs2[1 + it % 3] = 8'($urandom);
            setSub(1 + it % 3, IDX_AFS_TWO, afs2[1 + it % 3]);
            portData = $urandom;
            portDirOut = $urandom;
            afEnable = (it == 0) ? '0 : $urandom;
            afSelOne = $urandom;
            altOutData = {$urandom, $urandom, $urandom};
            altOutEn = {$urandom, $urandom, $urandom};
            settle(3);
            for (int i = PW; i < PINS; i++) `CHK({padOut[i], padOeN[i]}, expPin(i))
            `CHK(padHighDrive, {hde[3], hde[2], hde[1], hde[0]})
        end
        afEnable = '0;
        portData = '1;
        portDirOut = '1;
        openDrain = $urandom;
        settle(3);
        `CHK(padSourceOff, openDrain)
        `CHK(padOeN, openDrain)
        openDrain = '0;
        afEnable = 32'h000000FF;
        for (int it = 0; it < 8; it++) begin
            {timer_zero_output, t0Comp, timer_one_output, t1Comp, de, tx} = 6'($urandom);
            afSelOne = $urandom;
            setSub(0, IDX_AFS_TWO, 8'($urandom));
            settle(3);
            `CHK({padOut[7:5], padOut[2:0]}, {timer_one_output, t1Comp, tx, de, timer_zero_output, t0Comp})
        end
        timer_zero_input = 1'h1;
        timer_one_input = 1'h1;
        for (int it = 0; it < 4; it++) begin
            extLevel[7:0] = (it == 0) ? 8'h00 : 8'($urandom);
            settle(8);
            `CHK({t1Rx, rx, cts, t0Rx}, {extLevel[6], extLevel[4], extLevel[3], extLevel[0]})
        end
        afEnable = '0;
        extLevel[7:0] = 8'h00;
        settle(8);
        `CHK({cts, rx}, 2'h3)
        portDirOut = '0;
        for (int p = 0; p < NPORT; p++) setSub(p, IDX_WAKE_SRC, (p == 3) ? 8'h20 : 8'h00);
        settle(10);
        for (int k = 0; k < 3; k++) begin
            stopMode = 1'h1;
            extLevel[29] = ~extLevel[29];
            watchWake();
            `CHK(n, 1)
            extLevel[30] = ~extLevel[30];
            watchWake();
            `CHK(n, 0)
            stopMode = 1'h0;
            extLevel[29] = ~extLevel[29];
            watchWake();
            `CHK(n, 0)
        end
        summarize();
    end
endmodule
